// ---- design/cpm_defines.svh ----
// register offsets, field positions, reset values and timing counts of the power-mode control
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH

`define CPM_OFF_PWR        8'h00
`define CPM_OFF_OSC        8'h04
`define CPM_OFF_WAKE       8'h08
`define CPM_OFF_WDT        8'h0C
`define CPM_OFF_STAT       8'h10

`define CPM_PWR_IDLE_BIT   0
`define CPM_PWR_STOP_BIT   1
`define CPM_PWR_GF_LSB     2
`define CPM_OSC_SUSP_BIT   5
`define CPM_WAKE_PM_BIT    0
`define CPM_WAKE_CMP_BIT   1
`define CPM_WDT_EN_BIT     0
`define CPM_WDT_LOCK_BIT   1
`define CPM_WDT_KICK_BIT   2

`define CPM_GF_RESET       6'h00
`define CPM_OSC_RESET      8'h00
`define CPM_WAKE_RESET     2'h0
`define CPM_WDT_EN_RESET   1'h1
`define CPM_RESET_VECTOR   16'h0000

`define CPM_CLK_PERIOD_PS  25000
`define CPM_RST_HOLD_NS    250
`define CPM_RST_CYCLES     ((`CPM_RST_HOLD_NS * 1000 + `CPM_CLK_PERIOD_PS - 1) / `CPM_CLK_PERIOD_PS)

`endif

// ---- design/cpm_pkg.sv ----
// types shared by the power-mode control files
package cpm_pkg;

  typedef enum logic [4:0] {
    CPM_S_RST  = 5'h01,
    CPM_S_RUN  = 5'h02,
    CPM_S_IDLE = 5'h04,
    CPM_S_STOP = 5'h08,
    CPM_S_SUSP = 5'h10
  } cpm_state_type;

  typedef struct packed {
    logic        halt;
    logic        core_reset;
    logic        irq_service;
    logic        resume;
    logic [15:0] restart_pc;
  } cpm_core_type;

  typedef struct packed {
    logic int_osc_en;
    logic periph_en;
    logic irq_gate;
    logic timer_en;
    logic mcd_en;
  } cpm_clk_type;

endpackage

// ---- design/cpm_watchdog.sv ----
// watchdog counter: counts down while running, bites once at zero and reloads
`timescale 1ns/1ps
module cpm_watchdog #(
  parameter int               WIDTH = 17,
  parameter logic [WIDTH-1:0] LOAD  = {WIDTH{1'b1}}
) (
  input  logic pclk,
  input  logic presetn,
  input  logic run,
  input  logic kick,
  input  logic restart,
  output logic bite_q
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  wire              at_zero = (cnt_q == '0);

  // a kick or a device reset restarts the full timeout
  assign cnt_d = (kick | restart) ? LOAD :
                 !run             ? cnt_q :
                 at_zero          ? LOAD : cnt_q - WIDTH'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= LOAD;
      bite_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      bite_q <= run & at_zero & ~kick & ~restart;
    end
  end

endmodule

// ---- design/cpm_power_ctrl.sv ----
// power-mode control: idle, stop and suspend sequencing with apb registers
//
// Operation
// - idle entered after setting instruction completes
// - idle keeps state and peripheral clocks
// - idle ends only on interrupt or reset
// - interrupt wake clears idle bit, cpu resumes
// - service interrupt, then continue after setter
// - reset from idle restarts at vector zero
// - watchdog runs in idle and resets
// - stop halts cpu, timers, interrupts, oscillator
// - suspend halts cpu, wakes on events
// - stop/idle in power reg, suspend separate
// - stop entered after setting instruction completes
// - stop ends only on a reset
// - suspend wake continues after setting instruction
// - idle and stop bits read zero
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "cpm_defines.svh"
module cpm_power_ctrl
  import cpm_pkg::*;
#(
  parameter int WDT_CYCLES = 65536
) (
  input  logic         pclk,
  input  logic         presetn,
  input  logic         psel,
  input  logic         penable,
  input  logic         pwrite,
  input  logic [7:0]   paddr,
  input  logic [31:0]  pwdata,
  output logic [31:0]  prdata_q,
  output logic         pready_q,
  output logic         pslverr_q,
  input  logic         instr_done,
  input  logic         irq_pending,
  input  logic         ext_rst_n_pin,
  input  logic         port_match_pin,
  input  logic         comp_low_pin,
  output cpm_core_type core_q,
  output cpm_clk_type  clk_en_q
);

  localparam int       WDT_W    = 17;
  localparam int       RST_CYC  = `CPM_RST_CYCLES;
  localparam bit [3:0] RST_LOAD = 4'(RST_CYC - 1);

  // pin synchronisers: ext reset, port match, comparator low
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 3'h1;
      pin_sync_q <= 3'h1;
    end else begin
      pin_meta_q <= {comp_low_pin, port_match_pin, ext_rst_n_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  wire ext_rst_s  = ~pin_sync_q[0];
  wire port_mt_s  = pin_sync_q[1];
  wire comp_low_s = pin_sync_q[2];

  // apb decode
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pwrite & pready_q;
  wire hit_pwr   = (paddr == `CPM_OFF_PWR);
  wire hit_osc   = (paddr == `CPM_OFF_OSC);
  wire hit_wake  = (paddr == `CPM_OFF_WAKE);
  wire hit_wdt   = (paddr == `CPM_OFF_WDT);
  wire hit_stat  = (paddr == `CPM_OFF_STAT);
  wire addr_ok   = hit_pwr | hit_osc | hit_wake | hit_wdt | hit_stat;
  wire wr_pwr    = apb_wr & hit_pwr;
  wire wr_osc    = apb_wr & hit_osc;
  wire wr_wake   = apb_wr & hit_wake;
  wire wr_wdt    = apb_wr & hit_wdt;

  // control and status state
  cpm_state_type st_q;
  cpm_state_type st_d;
  logic [3:0]    rst_cnt_q;
  logic [3:0]    rst_cnt_d;
  logic [5:0]    gp_flags_q;
  logic          idle_req_q;
  logic          idle_req_d;
  logic          stop_req_q;
  logic          stop_req_d;
  logic [7:0]    osc_q;
  logic [7:0]    osc_d;
  logic [1:0]    wake_en_q;
  logic          wdt_en_q;
  logic          wdt_en_d;
  logic          wdt_lock_q;
  logic          wdt_bite;
  logic          wdt_cause_q;
  logic [1:0]    last_wake_q;

  wire rst_evt  = ext_rst_s | wdt_bite;
  wire susp_req = osc_q[`CPM_OSC_SUSP_BIT];
  wire ev_wake  = (wake_en_q[`CPM_WAKE_PM_BIT] & port_mt_s)
                | (wake_en_q[`CPM_WAKE_CMP_BIT] & comp_low_s);
  // a reset in the same cycle masks both wake paths
  wire wake_irq = (st_q == CPM_S_IDLE) & irq_pending & ~rst_evt;
  wire wake_ev  = (st_q == CPM_S_SUSP) & ev_wake & ~rst_evt;
  wire enter_ok = (st_q == CPM_S_RUN) & instr_done & ~rst_evt;

  // mode sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      CPM_S_RST: begin
        if (rst_cnt_q == 4'h0) begin
          st_d = CPM_S_RUN;
        end
      end
      CPM_S_RUN: begin
        // entry waits for the core to report that the setting instruction retired
        if (enter_ok && stop_req_q) begin
          st_d = CPM_S_STOP;
        end else if (enter_ok && susp_req) begin
          st_d = CPM_S_SUSP;
        end else if (enter_ok && idle_req_q) begin
          st_d = CPM_S_IDLE;
        end
      end
      CPM_S_IDLE: begin
        if (wake_irq) begin
          st_d = CPM_S_RUN;
        end
      end
      CPM_S_STOP: begin
        st_d = CPM_S_STOP;
      end
      CPM_S_SUSP: begin
        if (wake_ev) begin
          st_d = CPM_S_RUN;
        end
      end
      default: begin
        st_d = CPM_S_RST;
      end
    endcase
    if (rst_evt) begin
      st_d = CPM_S_RST;
    end
  end

  assign rst_cnt_d = rst_evt                                   ? RST_LOAD :
                     (st_q == CPM_S_RST && rst_cnt_q != 4'h0) ? rst_cnt_q - 4'h1 : rst_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= CPM_S_RST;
      rst_cnt_q <= RST_LOAD;
    end else begin
      st_q      <= st_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end

  // mode select bits: software sets, hardware clears idle on wake, reset clears both; set beats wake, reset beats set
  assign idle_req_d = rst_evt                                  ? 1'b0 :
                      (wr_pwr && pwdata[`CPM_PWR_IDLE_BIT])    ? 1'b1 :
                      wake_irq                                 ? 1'b0 : idle_req_q;
  assign stop_req_d = rst_evt                                  ? 1'b0 :
                      (wr_pwr && pwdata[`CPM_PWR_STOP_BIT])    ? 1'b1 : stop_req_q;

  always_comb begin
    osc_d = osc_q;
    if (wr_osc) begin
      osc_d = pwdata[7:0];
    end else if (wake_ev) begin
      osc_d[`CPM_OSC_SUSP_BIT] = 1'b0;
    end
    if (rst_evt) begin
      osc_d = `CPM_OSC_RESET;
    end
  end

  // once locked, a write cannot turn the watchdog off
  assign wdt_en_d = rst_evt ? `CPM_WDT_EN_RESET :
                    !wr_wdt ? wdt_en_q :
                    (wdt_lock_q && !pwdata[`CPM_WDT_EN_BIT]) ? 1'b1 : pwdata[`CPM_WDT_EN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_flags_q <= `CPM_GF_RESET;
      idle_req_q <= 1'b0;
      stop_req_q <= 1'b0;
      osc_q      <= `CPM_OSC_RESET;
      wake_en_q  <= `CPM_WAKE_RESET;
      wdt_en_q   <= `CPM_WDT_EN_RESET;
      wdt_lock_q <= 1'b0;
    end else begin
      idle_req_q <= idle_req_d;
      stop_req_q <= stop_req_d;
      osc_q      <= osc_d;
      wdt_en_q   <= wdt_en_d;
      if (rst_evt) begin
        gp_flags_q <= `CPM_GF_RESET;
        wake_en_q  <= `CPM_WAKE_RESET;
        wdt_lock_q <= 1'b0;
      end else begin
        if (wr_pwr) begin
          gp_flags_q <= pwdata[7:`CPM_PWR_GF_LSB];
        end
        if (wr_wake) begin
          wake_en_q <= pwdata[1:0];
        end
        if (wr_wdt && pwdata[`CPM_WDT_LOCK_BIT]) begin
          wdt_lock_q <= 1'b1;
        end
      end
    end
  end

  // wake cause and reset cause for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cause_q <= 1'b0;
      last_wake_q <= 2'h0;
    end else begin
      if (wdt_bite) begin
        wdt_cause_q <= 1'b1;
      end else if (ext_rst_s) begin
        wdt_cause_q <= 1'b0;
      end
      if (wake_irq || wake_ev) begin
        last_wake_q <= {wake_ev, wake_irq};
      end
    end
  end

  // the watchdog keeps counting through idle; the state decode halts it in reset, stop and suspend
  wire wdt_run  = wdt_en_q & ((st_q == CPM_S_RUN) | (st_q == CPM_S_IDLE));
  wire wdt_kick = wr_wdt & pwdata[`CPM_WDT_KICK_BIT];

  cpm_watchdog #(
    .WIDTH (WDT_W),
    .LOAD  (WDT_W'(WDT_CYCLES - 1))
  ) u_wdt (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (wdt_run),
    .kick    (wdt_kick),
    .restart (rst_evt),
    .bite_q  (wdt_bite)
  );

  // outputs follow the next state so they line up with st_q
  wire nx_run  = (st_d == CPM_S_RUN);
  wire nx_idle = (st_d == CPM_S_IDLE);
  wire nx_rst  = (st_d == CPM_S_RST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_q   <= '{halt: 1'b1, core_reset: 1'b1, irq_service: 1'b0, resume: 1'b0,
                    restart_pc: `CPM_RESET_VECTOR};
      clk_en_q <= '{int_osc_en: 1'b1, periph_en: 1'b0, irq_gate: 1'b0, timer_en: 1'b0,
                    mcd_en: 1'b1};
    end else begin
      core_q.halt        <= ~nx_run;
      core_q.core_reset  <= nx_rst;
      core_q.irq_service <= wake_irq | (wake_ev & irq_pending);
      core_q.resume      <= wake_irq | wake_ev;
      core_q.restart_pc  <= `CPM_RESET_VECTOR;
      clk_en_q.int_osc_en <= nx_run | nx_idle | nx_rst;
      clk_en_q.periph_en  <= nx_run | nx_idle;
      clk_en_q.irq_gate   <= nx_run | nx_idle;
      clk_en_q.timer_en   <= nx_run | nx_idle;
      clk_en_q.mcd_en     <= 1'b1;
    end
  end

  // apb read mux; mode select bits always read zero
  wire [31:0] rd_pwr  = {24'h000000, gp_flags_q, 2'h0};
  wire [31:0] rd_osc  = {24'h000000, osc_q};
  wire [31:0] rd_wake = {30'h00000000, wake_en_q};
  wire [31:0] rd_wdt  = {30'h00000000, wdt_lock_q, wdt_en_q};
  wire [31:0] rd_stat = {24'h000000, wdt_cause_q, last_wake_q, st_q};
  wire [31:0] rd_mux  = hit_pwr  ? rd_pwr  :
                        hit_osc  ? rd_osc  :
                        hit_wake ? rd_wake :
                        hit_wdt  ? rd_wdt  :
                        hit_stat ? rd_stat : 32'h00000000;

  // one wait-free access phase: answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~addr_ok;
      if (apb_setup && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence idle_irq_s;
    (st_q == CPM_S_IDLE) && irq_pending && !rst_evt;
  endsequence

  sequence wake_pulse_s;
    (st_q == CPM_S_RUN) && core_q.resume && !core_q.halt;
  endsequence

  a_idle_entry_after: assert property (
    (st_q == CPM_S_RUN) && instr_done && idle_req_q && !stop_req_q && !susp_req && !rst_evt
    |=> (st_q == CPM_S_IDLE) && core_q.halt)
    else $error("idle not entered after setting instruction");

  a_idle_clocks_on: assert property (
    (st_q == CPM_S_IDLE) |-> clk_en_q.periph_en && clk_en_q.int_osc_en && clk_en_q.timer_en)
    else $error("clocks stopped during idle");

  a_idle_exit_only: assert property (
    (st_q == CPM_S_IDLE) && !irq_pending && !rst_evt |=> (st_q == CPM_S_IDLE))
    else $error("idle left without interrupt or reset");

  a_irq_wake_clear: assert property (
    idle_irq_s |=> !idle_req_q ##0 wake_pulse_s)
    else $error("interrupt wake did not clear idle and resume");

  a_irq_serviced: assert property (
    idle_irq_s |=> core_q.irq_service ##1 !core_q.irq_service)
    else $error("pending interrupt not serviced once on wake");

  a_reset_vector: assert property (
    rst_evt |=> core_q.core_reset && core_q.halt && (core_q.restart_pc == `CPM_RESET_VECTOR))
    else $error("reset did not restart at vector");

  a_reset_hold: assert property (
    $rose(core_q.core_reset) |-> core_q.core_reset [*8])
    else $error("reset sequence too short");

  a_wdt_ends_idle: assert property (
    (st_q == CPM_S_IDLE) && wdt_bite |=> (st_q == CPM_S_RST))
    else $error("watchdog bite did not end idle");

  a_wdt_lock_holds: assert property (
    wdt_lock_q && wdt_en_q && !rst_evt |=> wdt_en_q)
    else $error("locked watchdog was disabled");

  a_stop_gates: assert property (
    (st_q == CPM_S_STOP) |-> core_q.halt && !clk_en_q.int_osc_en && !clk_en_q.irq_gate
                            && !clk_en_q.timer_en && clk_en_q.mcd_en)
    else $error("stop left clocks or interrupts running");

  a_stop_sticky: assert property (
    (st_q == CPM_S_STOP) && !rst_evt |=> (st_q == CPM_S_STOP))
    else $error("stop left without reset");

  a_susp_wake: assert property (
    (st_q == CPM_S_SUSP) && ev_wake && !rst_evt |=> wake_pulse_s ##0 !osc_q[`CPM_OSC_SUSP_BIT])
    else $error("suspend wake did not resume");

  a_mode_bits_zero: assert property (
    apb_setup && !pwrite && hit_pwr |=> pready_q && (prdata_q[1:0] == 2'h0))
    else $error("mode select bits read nonzero");

  a_reset_priority: assert property (
    (st_q == CPM_S_IDLE) && irq_pending && rst_evt |=> (st_q == CPM_S_RST) && !core_q.resume)
    else $error("interrupt beat reset");

endmodule

// ---- bench/cpm_core_model.sv ----
// core-side model: retires instructions on request and holds interrupts until served or core reset
`timescale 1ns/1ps
module cpm_core_model
  import cpm_pkg::*;
(
  input  logic         pclk,
  input  logic         presetn,
  input  cpm_core_type core,
  input  logic         step,
  input  logic [3:0]   lag,
  input  logic         irq_req,
  output logic         instr_done,
  output logic         irq_pending
);
  logic [3:0] wait_q;
  logic       busy_q;
  // a halted core retires nothing, so the opcode after a mode setter waits for the wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q      <= 1'b0;
      wait_q      <= 4'h0;
      instr_done  <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      if (irq_req)
        irq_pending <= 1'b1;
      else if (core.irq_service || core.core_reset)
        irq_pending <= 1'b0;
      if (step && !busy_q) begin
        busy_q <= 1'b1;
        wait_q <= lag;
      end else if (busy_q && !core.halt && wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      else if (busy_q && !core.halt) begin
        busy_q     <= 1'b0;
        instr_done <= 1'b1;
      end
    end
  end
endmodule

// ---- bench/cpm_power_ctrl_tb.sv ----
// self-checking bench of the power-mode control with a core-side model
`timescale 1ns/1ps
`include "cpm_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module cpm_power_ctrl_tb
  import cpm_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, ee;
  logic [7:0]   paddr, osc;
  logic [31:0]  pwdata, prdata_q, rnd, rr;
  logic         pready_q, pslverr_q, instr_done, irq_pending, ext_rst_n_pin;
  logic         port_match_pin, comp_low_pin, step, irq_req;
  logic [3:0]   lag;
  logic [5:0]   gf;
  cpm_core_type core_q;
  cpm_clk_type  clk_en_q;
  int           errors = 0, n_compared = 0, n_resume = 0, n_service = 0;
  int           exp_wake = 0, exp_svc = 0, k;

  cpm_power_ctrl #(.WDT_CYCLES(96)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .instr_done(instr_done), .irq_pending(irq_pending), .ext_rst_n_pin(ext_rst_n_pin),
    .port_match_pin(port_match_pin), .comp_low_pin(comp_low_pin), .core_q(core_q),
    .clk_en_q(clk_en_q));
  cpm_core_model core (.pclk(pclk), .presetn(presetn), .core(core_q), .step(step),
    .lag(lag), .irq_req(irq_req), .instr_done(instr_done), .irq_pending(irq_pending));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // pulses are counted at the falling edge where they are settled
  always @(negedge pclk) begin
    if (core_q.resume === 1'b1) n_resume++;
    if (core_q.irq_service === 1'b1) n_service++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task give_verdict;
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ready, read data and error are all taken at the rising edge that ends the access
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    if (pready_q !== 1'b1) errors++;
    r = prdata_q;
    e = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rr, ee);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm,
                    input logic [31:0] m = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h0, rr, ee);
    `CHK(nm, x, rr & m)
  endtask

  // which: 0 watches halt, 1 watches core_reset; a long wait counts as a mismatch
  task automatic wait_for(input int which, input logic v);
    int n;
    n = 0;
    while ((which == 0 ? core_q.halt : core_q.core_reset) !== v && n < 400) begin
      @(negedge pclk);
      n++;
    end
    if (n == 400) errors++;
    @(posedge pclk);
  endtask

  task automatic retire(input logic [3:0] l);
    lag  <= l;
    step <= 1'b1;
    @(posedge pclk);
    step <= 1'b0;
  endtask

  task automatic irq_pulse;
    irq_req <= 1'b1;
    @(posedge pclk);
    irq_req <= 1'b0;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, step, lag, irq_req} = '0;
    {port_match_pin, comp_low_pin, ext_rst_n_pin, presetn} = 4'b0010;
    rnd = 32'hBF6F;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(0, 1'b0);
    rd(`CPM_OFF_STAT, {27'h0, CPM_S_RUN}, "stat", 32'h9F);
    rd(`CPM_OFF_PWR, 32'h0, "pwr");
    rd(`CPM_OFF_WDT, 32'h1, "wdt");
    rd(`CPM_OFF_OSC, 32'h0, "osc");
    apb(1'b0, 8'h20, 32'h0, rr, ee);
    `CHK("unmapped", 1'b1, ee)
    // watchdog off so that idle and suspend last as long as the bench wants
    wr(`CPM_OFF_WDT, 32'h0);
    for (k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      gf  = rnd[5:0];
      wr(`CPM_OFF_PWR, {24'h0, gf, 2'b01});
      retire(4'(k * 3));
      wait_for(0, 1'b1);
      `CHK("idle clk", 5'h1F, clk_en_q)
      rd(`CPM_OFF_STAT, {27'h0, CPM_S_IDLE}, "stat", 32'h1F);
      repeat (rnd[11:8] + 2) @(negedge pclk);
      `CHK("idle hold", 1'b1, core_q.halt)
      @(posedge pclk);
      irq_pulse();
      wait_for(0, 1'b0);
      exp_wake++;
      exp_svc++;
      `CHK("resume", exp_wake, n_resume)
      `CHK("service", exp_svc, n_service)
      rd(`CPM_OFF_PWR, {24'h0, gf, 2'b00}, "pwr");
      rd(`CPM_OFF_STAT, 32'h22, "stat wake");
      retire(4'h0);
      repeat (4) @(negedge pclk);
      `CHK("no reentry", 1'b0, core_q.halt)
      @(posedge pclk);
    end
    for (k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      osc = {rnd[7:6], 1'b1, rnd[4:0]};
      wr(`CPM_OFF_WAKE, 32'(1 << k));
      wr(`CPM_OFF_OSC, {24'h0, osc});
      retire(4'h2);
      wait_for(0, 1'b1);
      `CHK("susp clk", 5'h01, clk_en_q)
      rd(`CPM_OFF_STAT, {27'h0, CPM_S_SUSP}, "stat", 32'h1F);
      // an interrupt left pending through suspend must be served on the event wake
      if (k == 1) irq_pulse();
      if (k == 0) port_match_pin <= 1'b1;
      else comp_low_pin <= 1'b1;
      wait_for(0, 1'b0);
      {port_match_pin, comp_low_pin} <= 2'b00;
      exp_wake++;
      `CHK("resume", exp_wake, n_resume)
      exp_svc += k;
      `CHK("service", exp_svc, n_service)
      rd(`CPM_OFF_OSC, {24'h0, osc & 8'hDF}, "osc");
      rd(`CPM_OFF_STAT, 32'h42, "stat wake");
    end
    wr(`CPM_OFF_PWR, {24'h0, gf, 2'b10});
    retire(4'h1);
    wait_for(0, 1'b1);
    `CHK("stop clk", 5'h01, clk_en_q)
    irq_pulse();
    rd(`CPM_OFF_STAT, {27'h0, CPM_S_STOP}, "stat", 32'h1F);
    `CHK("stop hold", 1'b1, core_q.halt)
    ext_rst_n_pin <= 1'b0;
    wait_for(1, 1'b1);
    `CHK("vector", 16'h0000, core_q.restart_pc)
    ext_rst_n_pin <= 1'b1;
    wait_for(0, 1'b0);
    rd(`CPM_OFF_PWR, 32'h0, "pwr");
    `CHK("resume", exp_wake, n_resume)
    wr(`CPM_OFF_WDT, 32'h0);
    wr(`CPM_OFF_PWR, 32'h1);
    retire(4'h0);
    wait_for(0, 1'b1);
    // interrupt lands on the very edge where the synced reset is seen
    ext_rst_n_pin <= 1'b0;
    @(posedge pclk);
    irq_pulse();
    wait_for(1, 1'b1);
    ext_rst_n_pin <= 1'b1;
    wait_for(0, 1'b0);
    `CHK("reset wins", exp_wake, n_resume)
    wr(`CPM_OFF_WDT, 32'h3);
    wr(`CPM_OFF_WDT, 32'h0);
    rd(`CPM_OFF_WDT, 32'h3, "wdt lock", 32'h3);
    // kicks well inside the timeout keep the watchdog from biting
    repeat (2) begin
      wr(`CPM_OFF_WDT, 32'h7);
      repeat (60) @(posedge pclk);
    end
    rd(`CPM_OFF_STAT, 32'h02, "no bite", 32'h82);
    wr(`CPM_OFF_PWR, 32'h1);
    retire(4'h0);
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    wait_for(0, 1'b0);
    rd(`CPM_OFF_STAT, 32'h82, "stat wdt", 32'h9F);
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict;
  end
endmodule
